//--- shared/sbc_pkg.sv
// Shared constants and types for the sequencer branch control block
package sbc_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_FLAGS   = 8'h04;
    localparam logic [7:0] ADDR_START   = 8'h08;
    localparam logic [7:0] ADDR_DPTR    = 8'h0C;
    localparam logic [7:0] ADDR_DDATA   = 8'h10;
    localparam logic [7:0] ADDR_STATUS  = 8'h14;
    localparam logic [7:0] ADDR_IRQADDR = 8'h18;
    localparam logic [7:0] ADDR_DIAG    = 8'h1C;
    // Control register bit positions
    localparam int CTRL_RUN   = 0;
    localparam int CTRL_ARE   = 1;
    localparam int CTRL_INIT  = 2;
    localparam int CTRL_WSCSI = 3;
    localparam int CTRL_WDMA  = 4;
    localparam int CTRL_SRST  = 7;
    // Status register bit positions
    localparam int ST_RUN  = 0;
    localparam int ST_LAST = 1;
    localparam int ST_IRQ  = 2;
    localparam int ST_RESV = 3;
    localparam int ST_ODD  = 4;
    localparam int ST_BKUP = 5;
    localparam int ST_HALT = 6;
    // Reset values and the pad byte
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [6:0] PC_RST    = 7'h00;
    localparam logic [7:0] PAD_BYTE  = 8'h00;
    // Condition codes with fixed meaning
    localparam logic [4:0] CC_PHASE = 5'h10;
    localparam logic [4:0] CC_ATN   = 5'h11;
    localparam logic [4:0] CC_IDF   = 5'h12;
    localparam logic [4:0] CC_IMM   = 5'h13;
    localparam logic [4:0] CC_LAST  = 5'h14;
    localparam logic [4:0] CC_TCZ   = 5'h15;
    localparam logic [4:0] CC_ALW   = 5'h16;
    // Reset mode stretch after the pin or the soft bit
    localparam int CLK_PERIOD_NS = 100;
    localparam int RST_HOLD_NS   = 400;
    localparam logic [2:0] RST_HOLD_CYC =
        3'((RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // One control store word, as seen by this block
    typedef struct packed {
        logic [4:0] exec_control_code;
        logic [6:0] branch_target;
        logic       halt_sel;
        logic       invert;
        logic       irq_req;
        logic [3:0] count_field;
        logic [3:0] phase_field;
        logic       fifo_xfer;
    } sbc_instr_t;

    // Bus and count state sampled at evaluation
    typedef struct packed {
        logic [3:0] bus_phase;
        logic       atn;
        logic       id_match;
        logic       tc_zero;
        logic       tc_pipe_empty;
        logic       tc_final_load;
    } sbc_bus_t;

    typedef enum logic [4:0] {
        SBC_IDLE = 5'b0_0001,
        SBC_XFER = 5'b0_0010,
        SBC_POST = 5'b0_0100,
        SBC_CMPW = 5'b0_1000,
        SBC_EVAL = 5'b1_0000
    } sbc_seq_t;

    // Complete module state
    typedef struct packed {
        sbc_seq_t   st;
        logic [6:0] pc;
        logic [6:0] start_pc;
        logic       are;
        logic       initiator;
        logic       wide_scsi;
        logic       wide_dma;
        logic [7:0] flags;
        logic [4:0] dptr;
        logic       last;
        logic       irq_flag;
        logic [6:0] irq_addr;
        logic       resv;
        logic       byte_odd;
        logic       backup_req;
        logic       final_word;
        logic       pad_word;
        logic       halted;
        logic [2:0] rst_cnt;
        logic       soft_rst;
        logic [7:0] rdata;
    } sbc_state_t;
endpackage : sbc_pkg

//--- logic/sbc_branch_ctl.sv
// Sequencer execution control: branch test, halt, irq, reset mode, odd bytes
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns

// Behaviour
// - Test condition only after transfer and errors
// - Codes 0-7 test user condition flags
// - Codes 8-F test masked compares 0-7
// - Code 10 tests phase field against bus
// - Code 11 true while ATN asserted
// - Code 12 tests identification match flag
// - Code 13 compares immediate byte with store
// - Code 14 tests zero count from final load
// - Code 15 tests empty pipeline and zero count
// - Code 16 is always true
// - Last flag set at zero, cleared next transfer
// - Compare waits for store writes, uses pointer
// - Compare and evaluate first, then branch
// - Irq bit sets flag and latches address
// - Target with enable answers ATN; target skips phase check
// - Initiator mismatch with enable pauses to evaluation
// - Invert bit takes branch on false condition
// - Halt select one halts, zero jumps
// - Byte zero even, parity kept over disconnect
// - Wide odd disconnect: word or backup request
// - Narrow bus, wide DMA: pad with zero
// - Reset mode: defaults, diag reads, no writes
// - Pin or soft bit enter stretched reset mode
// - Residues valid on clean stop, else invalid
module sbc_branch_ctl #(
    parameter int DPS_DEPTH = 32
) (
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    input  wire logic                hw_reset_pin_n,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [7:0]          reg_rdata,
    input  wire sbc_pkg::sbc_instr_t instr,
    input  wire sbc_pkg::sbc_bus_t   bus_stat,
    input  wire logic [7:0]          masked_cmp,
    input  wire logic                xfer_done,
    input  wire logic                phase_mismatch,
    input  wire logic                dps_wr_busy,
    input  wire logic                dps_wr,
    input  wire logic [7:0]          dps_wdata,
    input  wire logic                byte_moved,
    input  wire logic                odd_disconnect,
    input  wire logic                clean_stop,
    input  wire logic                residue_kill,
    output logic      [6:0]          seq_addr,
    output logic                     seq_running,
    output logic                     seq_irq_flag,
    output logic                     last_flag,
    output logic                     residue_valid,
    output logic                     final_word,
    output logic                     pad_word,
    output logic      [7:0]          pad_byte,
    output logic                     reset_mode
);
    localparam int PW = $clog2(DPS_DEPTH);

    sbc_pkg::sbc_state_t s;
    sbc_pkg::sbc_state_t next_s;
    logic [7:0] dps_mem [DPS_DEPTH];
    logic [7:0] dps_byte;
    logic       cond;
    logic       take;
    logic       wr_ok;

    // Condition select by execution control code
    function automatic logic cond_eval(input sbc_pkg::sbc_instr_t i,
                                       input logic [7:0] flg,
                                       input logic [7:0] mc,
                                       input sbc_pkg::sbc_bus_t b,
                                       input logic [7:0] db);
        logic r;
        r = 1'b0;
        if (i.exec_control_code[4:3] == 2'b00) begin
            r = flg[i.exec_control_code[2:0]];
        end else if (i.exec_control_code[4:3] == 2'b01) begin
            r = mc[i.exec_control_code[2:0]];
        end else begin
            case (i.exec_control_code)
                sbc_pkg::CC_PHASE: r = (i.phase_field == b.bus_phase);
                sbc_pkg::CC_ATN:   r = b.atn;
                sbc_pkg::CC_IDF:   r = b.id_match;
                sbc_pkg::CC_IMM:   r = ({i.phase_field, i.count_field} == db);
                sbc_pkg::CC_LAST:  r = b.tc_zero && b.tc_final_load;
                sbc_pkg::CC_TCZ:   r = b.tc_pipe_empty && b.tc_zero;
                sbc_pkg::CC_ALW:   r = 1'b1;
                default:           r = 1'b0;
            endcase
        end
        return r;
    endfunction : cond_eval

    // Byte at the store pointer, always the compare source
    assign dps_byte = dps_mem[s.dptr[PW-1:0]];

    // Branch decision with optional inversion
    always_comb begin
        cond = cond_eval(instr, s.flags, masked_cmp, bus_stat, dps_byte);
        take = cond ^ instr.invert;
    end

    // Writes are refused in reset mode
    assign wr_ok = reg_wr && !s.soft_rst;

    // Next state
    always_comb begin
        next_s            = s;
        next_s.final_word = 1'b0;
        next_s.pad_word   = 1'b0;
        next_s.rdata      = 8'h00;

        // Sequencer flow
        unique case (s.st)
            sbc_pkg::SBC_IDLE: begin
                if (wr_ok && reg_addr == sbc_pkg::ADDR_CTRL && reg_wdata[sbc_pkg::CTRL_RUN]) begin
                    next_s.st     = sbc_pkg::SBC_XFER;
                    next_s.pc     = s.start_pc;
                    next_s.halted = 1'b0;
                end
            end
            sbc_pkg::SBC_XFER: begin
                if (xfer_done) begin
                    next_s.st = sbc_pkg::SBC_POST;
                end else if (s.initiator && s.are && phase_mismatch) begin
                    next_s.st = sbc_pkg::SBC_POST;
                end else if (!s.initiator && s.are && bus_stat.atn) begin
                    next_s.st = sbc_pkg::SBC_POST;
                end
            end
            sbc_pkg::SBC_POST: begin
                // Interrupt address latched before the test
                if (instr.irq_req) begin
                    next_s.irq_addr = s.pc;
                end
                if (instr.fifo_xfer && bus_stat.tc_zero && bus_stat.tc_final_load) begin
                    next_s.last = 1'b1;
                end
                next_s.st = sbc_pkg::SBC_CMPW;
            end
            sbc_pkg::SBC_CMPW: begin
                if (!dps_wr_busy && !dps_wr) begin
                    next_s.st = sbc_pkg::SBC_EVAL;
                end
            end
            sbc_pkg::SBC_EVAL: begin
                // Compare result drives the branch in this cycle
                if (take && instr.halt_sel) begin
                    next_s.st     = sbc_pkg::SBC_IDLE;
                    next_s.halted = 1'b1;
                end else if (take) begin
                    next_s.st = sbc_pkg::SBC_XFER;
                    next_s.pc = instr.branch_target;
                end else begin
                    next_s.st = sbc_pkg::SBC_XFER;
                    next_s.pc = 7'(s.pc + 7'h01);
                end
            end
        endcase

        // New fifo transfer: last flag drops, byte parity restarts if last was set
        if (s.st == sbc_pkg::SBC_XFER && instr.fifo_xfer) begin
            next_s.last = 1'b0;
            if (s.last) begin
                next_s.byte_odd = 1'b0;
            end
        end
        if (byte_moved) begin
            next_s.byte_odd = !next_s.byte_odd;
        end

        // Odd byte disconnect as initiator
        if (odd_disconnect && s.initiator) begin
            if (s.wide_scsi && s.wide_dma) begin
                next_s.final_word = 1'b1;
            end else if (!s.wide_scsi && s.wide_dma) begin
                next_s.pad_word = 1'b1;
            end
        end

        // Register writes
        if (wr_ok) begin
            unique case (reg_addr)
                sbc_pkg::ADDR_CTRL: begin
                    next_s.are       = reg_wdata[sbc_pkg::CTRL_ARE];
                    next_s.initiator = reg_wdata[sbc_pkg::CTRL_INIT];
                    next_s.wide_scsi = reg_wdata[sbc_pkg::CTRL_WSCSI];
                    next_s.wide_dma  = reg_wdata[sbc_pkg::CTRL_WDMA];
                end
                sbc_pkg::ADDR_FLAGS: next_s.flags    = reg_wdata;
                sbc_pkg::ADDR_START: next_s.start_pc = reg_wdata[6:0];
                sbc_pkg::ADDR_DPTR:  next_s.dptr     = reg_wdata[4:0];
                sbc_pkg::ADDR_STATUS: begin
                    // Clear first, hardware set below wins
                    if (reg_wdata[sbc_pkg::ST_IRQ]) begin
                        next_s.irq_flag = 1'b0;
                    end
                    if (reg_wdata[sbc_pkg::ST_BKUP]) begin
                        next_s.backup_req = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (s.st == sbc_pkg::SBC_POST && instr.irq_req) begin
            next_s.irq_flag = 1'b1;
        end
        if (odd_disconnect && s.initiator && s.wide_scsi && !s.wide_dma) begin
            next_s.backup_req = 1'b1;
        end

        // Residue validity
        if (clean_stop) begin
            next_s.resv = 1'b1;
        end
        if (residue_kill) begin
            next_s.resv = 1'b0;
        end

        // Register reads, answered next cycle; reset mode overrides below
        if (reg_rd) begin
            unique case (reg_addr)
                sbc_pkg::ADDR_CTRL: begin
                    next_s.rdata = {3'b000, s.wide_dma, s.wide_scsi,
                                    s.initiator, s.are, 1'b0};
                end
                sbc_pkg::ADDR_FLAGS:   next_s.rdata = s.flags;
                sbc_pkg::ADDR_START:   next_s.rdata = {1'b0, s.start_pc};
                sbc_pkg::ADDR_DPTR:    next_s.rdata = {3'b000, s.dptr};
                sbc_pkg::ADDR_DDATA:   next_s.rdata = dps_byte;
                sbc_pkg::ADDR_STATUS: begin
                    next_s.rdata = {1'b0, s.halted, s.backup_req, s.byte_odd,
                                    s.resv, s.irq_flag, s.last,
                                    (s.st != sbc_pkg::SBC_IDLE)};
                end
                sbc_pkg::ADDR_IRQADDR: next_s.rdata = {1'b0, s.irq_addr};
                default:               next_s.rdata = 8'h00;
            endcase
        end

        // Soft reset request
        if (wr_ok && reg_addr == sbc_pkg::ADDR_CTRL && reg_wdata[sbc_pkg::CTRL_SRST]) begin
            next_s.soft_rst = 1'b1;
            next_s.rst_cnt  = sbc_pkg::RST_HOLD_CYC;
        end

        // Reset mode: defaults everywhere, soft bit held until exit
        if (!hw_reset_pin_n || s.soft_rst) begin
            next_s            = '0;
            next_s.st         = sbc_pkg::SBC_IDLE;
            next_s.flags      = sbc_pkg::FLAGS_RST;
            next_s.pc         = sbc_pkg::PC_RST;
            next_s.start_pc   = sbc_pkg::PC_RST;
            next_s.soft_rst   = 1'b1;
            next_s.rdata      = (reg_rd && reg_addr == sbc_pkg::ADDR_DIAG) ? 8'h01 : 8'h00;
            if (!hw_reset_pin_n) begin
                next_s.rst_cnt = sbc_pkg::RST_HOLD_CYC;
            end else if (s.rst_cnt > 3'h1) begin
                next_s.rst_cnt = 3'(s.rst_cnt - 3'h1);
            end else begin
                next_s.rst_cnt  = 3'h0;
                next_s.soft_rst = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s          <= '0;
            s.st       <= sbc_pkg::SBC_IDLE;
            s.flags    <= sbc_pkg::FLAGS_RST;
            s.pc       <= sbc_pkg::PC_RST;
            s.start_pc <= sbc_pkg::PC_RST;
        end else begin
            s <= next_s;
        end
    end

    // Dual port store: transfer writes and processor data writes
    always_ff @(posedge sys_clk) begin
        if (dps_wr) begin
            dps_mem[s.dptr[PW-1:0]] <= dps_wdata;
        end else if (wr_ok && reg_addr == sbc_pkg::ADDR_DDATA) begin
            dps_mem[s.dptr[PW-1:0]] <= reg_wdata;
        end
    end

    // Outputs straight from the state register, pad byte a constant
    assign reg_rdata     = s.rdata;
    assign seq_addr      = s.pc;
    assign seq_running   = (s.st != sbc_pkg::SBC_IDLE);
    assign seq_irq_flag  = s.irq_flag;
    assign last_flag     = s.last;
    assign residue_valid = s.resv;
    assign final_word    = s.final_word;
    assign pad_word      = s.pad_word;
    assign pad_byte      = sbc_pkg::PAD_BYTE;
    assign reset_mode    = s.soft_rst;
endmodule : sbc_branch_ctl

//--- bench/sbc_branch_ctl_properties.sv
// Port checks for the sequencer branch control block
`timescale 1ns/1ns
module sbc_branch_ctl_properties (
    input wire logic                sys_clk,
    input wire logic                rst_n,
    input wire logic                hw_reset_pin_n,
    input wire logic [7:0]          reg_addr,
    input wire logic [7:0]          reg_wdata,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [7:0]          reg_rdata,
    input wire sbc_pkg::sbc_instr_t instr,
    input wire logic                xfer_done,
    input wire logic                clean_stop,
    input wire logic                residue_kill,
    input wire logic [6:0]          seq_addr,
    input wire logic                seq_running,
    input wire logic                seq_irq_flag,
    input wire logic                residue_valid,
    input wire logic                pad_word,
    input wire logic [7:0]          pad_byte,
    input wire logic                reset_mode
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Sequencing after the transfer end
    AST_EVAL_LATE: assert property (
        xfer_done && seq_running |=> $stable(seq_addr) [*3]) else $error("address moved early");
    AST_JUMP: assert property (
        xfer_done && seq_running && instr.exec_control_code == sbc_pkg::CC_ALW
        && !instr.halt_sel && !instr.invert |-> ##[3:20] seq_addr == instr.branch_target)
        else $error("no jump to target");
    AST_HALT: assert property (
        xfer_done && seq_running && instr.exec_control_code == sbc_pkg::CC_ALW
        && instr.halt_sel && !instr.invert |-> ##[3:20] !seq_running) else $error("no halt");
    AST_IRQ_CAUSE: assert property (
        $rose(seq_irq_flag) |-> $past(instr.irq_req)) else $error("irq without request");
    // Reset mode entry, stretch and reads; pad word and residue validity
    AST_SOFT_RST: assert property (
        reg_wr && reg_addr == sbc_pkg::ADDR_CTRL && reg_wdata[7] && !reset_mode
        |=> reset_mode [*3] ##[1:2] !reset_mode) else $error("soft reset length wrong");
    AST_PIN_RST: assert property (
        !hw_reset_pin_n |=> reset_mode) else $error("pin low without reset mode");
    AST_PIN_STRETCH: assert property (
        $rose(hw_reset_pin_n) |-> reset_mode [*3]) else $error("reset mode not stretched");
    AST_RST_READ: assert property (
        reset_mode && reg_rd |=> reg_rdata == ($past(reg_addr) == sbc_pkg::ADDR_DIAG ?
        8'h01 : 8'h00)) else $error("read in reset mode wrong");
    AST_PAD: assert property (
        pad_word |-> pad_byte == 8'h00 ##1 !pad_word) else $error("pad word wrong");
    AST_RES_KILL: assert property (
        residue_kill |=> !residue_valid) else $error("residue valid after kill");
    AST_RES_CLEAN: assert property (
        clean_stop && !residue_kill |=> residue_valid) else $error("residue not valid");
endmodule : sbc_branch_ctl_properties

bind sbc_branch_ctl sbc_branch_ctl_properties u_sbc_branch_ctl_properties (.*);

//--- bench/sbc_far_end.sv
// Transfer side model: ends each transfer, then writes the store late
`timescale 1ns/1ns
module sbc_far_end (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       seq_running,
    input  wire logic [6:0] seq_addr,
    input  wire logic [7:0] xfer_delay,
    input  wire logic [7:0] store_byte,
    output logic            xfer_done,
    output logic            dps_wr_busy,
    output logic            dps_wr,
    output logic [7:0]      dps_wdata
);
    logic       armed;
    logic       run_q;
    logic [6:0] last_addr;
    logic [7:0] cnt;
    logic [1:0] post;

    // Store stays busy for two cycles after the transfer end
    assign dps_wr_busy = (post != 2'd0);

    // New instruction seen: count down, then end the transfer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            {xfer_done, dps_wr, armed, run_q} <= '0;
            {cnt, last_addr, post} <= '0;
            dps_wdata <= 8'h00;
        end else begin
            run_q <= seq_running;
            last_addr <= seq_addr;
            xfer_done <= 1'b0;
            if (seq_running && (!run_q || seq_addr != last_addr)) begin
                armed <= 1'b1;
                cnt <= xfer_delay;
            end else if (!seq_running) begin
                armed <= 1'b0;
            end else if (armed && cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end else if (armed) begin
                armed <= 1'b0;
                xfer_done <= 1'b1;
            end
            if (armed && seq_running && cnt == 8'h00 && run_q && seq_addr == last_addr) begin
                post <= 2'd2;
            end else if (post != 2'd0) begin
                post <= post - 2'd1;
            end
            dps_wr <= (post == 2'd1);
            dps_wdata <= (post == 2'd1) ? store_byte : ~store_byte;
        end
    end
endmodule : sbc_far_end

//--- bench/sbc_branch_ctl_tb.sv
// Self-checking bench for the sequencer branch control block
`timescale 1ns/1ns
module sbc_branch_ctl_tb;
    logic sys_clk = 1'b0;
    logic rst_n, hw_reset_pin_n, reg_wr, reg_rd, xfer_done, phase_mismatch, dps_wr_busy;
    logic dps_wr, byte_moved, odd_disconnect, clean_stop, residue_kill, seq_running;
    logic seq_irq_flag, last_flag, residue_valid, final_word, pad_word, reset_mode;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, masked_cmp, dps_wdata, pad_byte;
    logic [7:0] xfer_delay, store_byte, flg;
    logic [6:0] seq_addr;
    logic [15:0] expq[$];
    logic [15:0] e_q;
    logic imm, rd_q = 1'b0;
    logic [31:0] seed = 32'haa91_1bb7;
    int num_errors = 0;
    int tests_run = 0;
    int pw, fw, k;
    sbc_pkg::sbc_instr_t instr, iw;
    sbc_pkg::sbc_bus_t bus_stat;

    sbc_branch_ctl u_sbc_branch_ctl (.*);
    sbc_far_end u_sbc_far_end (.*);

    always #50 sys_clk = ~sys_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        for (int b = 0; b < 32; b++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        return s;
    endfunction : lfsr
    // Expected branch decision
    function automatic logic cond(input sbc_pkg::sbc_instr_t i, input logic [7:0] f, m, db);
        case (i.exec_control_code) inside
            [5'h00:5'h07]: cond = f[i.exec_control_code[2:0]];
            [5'h08:5'h0F]: cond = m[i.exec_control_code[2:0]];
            5'h10: cond = i.phase_field == bus_stat.bus_phase;
            5'h11: cond = bus_stat.atn;
            5'h12: cond = bus_stat.id_match;
            5'h13: cond = {i.phase_field, i.count_field} == db;
            5'h14: cond = bus_stat.tc_zero && bus_stat.tc_final_load;
            5'h15: cond = bus_stat.tc_pipe_empty && bus_stat.tc_zero;
            5'h16: cond = 1'b1;
            default: cond = 1'b0;
        endcase
        return cond ^ i.invert;
    endfunction : cond

    task automatic end_sim;
        $display("Checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic guard(input int n, input int b);
        if (n >= b) begin
            num_errors++;
            $display("[ERR] %0t wait timed out", $time);
            end_sim();
        end
    endtask : guard
    task automatic tick(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge sys_clk);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        expq.push_back({m, e & m});
        reg_addr <= a;
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : rd
    // One instruction at 0x10, then a halting word
    task automatic run(input sbc_pkg::sbc_instr_t i, input logic [7:0] c, input logic pm);
        logic [6:0] ex;
        ex = cond(i, flg, masked_cmp, store_byte) ? i.branch_target : 7'h11;
        instr <= i;
        wr(sbc_pkg::ADDR_START, 8'h10);
        wr(sbc_pkg::ADDR_CTRL, c | 8'h01);
        tick(3);
        phase_mismatch <= pm;
        tick(1);
        phase_mismatch <= 1'b0;
        for (k = 0; k < 60 && seq_addr === 7'h10; k++) tick(1);
        guard(k, 60);
        chk({1'b0, seq_addr}, {1'b0, ex});
        chk({7'h00, seq_irq_flag}, {7'h00, i.irq_req});
        chk(8'(last_flag), 8'(i.fifo_xfer & bus_stat.tc_zero & bus_stat.tc_final_load));
        if (c[1]) chk(8'(k < 12), 8'h01);
        instr <= '{exec_control_code: sbc_pkg::CC_ALW, halt_sel: 1'b1, default: '0};
        for (k = 0; k < 60 && seq_running === 1'b1; k++) tick(1);
        guard(k, 60);
        if (i.irq_req) rd(sbc_pkg::ADDR_IRQADDR, 8'h10, 8'h7F);
        wr(sbc_pkg::ADDR_STATUS, 8'h24);
        tick(1);
    endtask : run

    // Read data stands only in the cycle after the strobe
    always @(posedge sys_clk) rd_q <= reg_rd;
    always @(negedge sys_clk) begin
        if (rd_q === 1'b1 && expq.size() > 0) begin
            e_q = expq.pop_front();
            chk(reg_rdata & e_q[15:8], e_q[7:0]);
        end
    end

    initial begin
        {reg_wr, reg_rd, phase_mismatch, byte_moved, odd_disconnect} = '0;
        {clean_stop, residue_kill, reg_addr, reg_wdata, masked_cmp, flg} = '0;
        {instr, bus_stat, rst_n} = '0;
        hw_reset_pin_n = 1'b1;
        xfer_delay = 8'h02;
        store_byte = 8'h3C;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        tick(1);
        rd(sbc_pkg::ADDR_CTRL, 8'h00, 8'hFF);
        rd(sbc_pkg::ADDR_FLAGS, sbc_pkg::FLAGS_RST, 8'hFF);
        rd(8'hFC, 8'h00, 8'hFF);
        // Every condition code, with random operands
        for (int n = 0; n < 64; n++) begin
            seed = lfsr(seed);
            iw = seed[23:0];
            iw.exec_control_code = 5'(n % 23);
            imm = iw.exec_control_code == sbc_pkg::CC_IMM;
            iw.branch_target = {1'b1, seed[29:24]};
            iw.halt_sel = 1'b0;
            iw.invert = n[5] & seed[30];
            if (imm && seed[9]) {iw.phase_field, iw.count_field} = seed[31:24];
            flg = seed[7:0] ^ seed[31:24];
            masked_cmp <= seed[15:8];
            bus_stat <= seed[20:12];
            store_byte <= seed[31:24];
            xfer_delay <= {5'h00, seed[2:0]} + 8'h01;
            wr(sbc_pkg::ADDR_FLAGS, flg);
            if (imm) wr(sbc_pkg::ADDR_DPTR, {3'h0, seed[15:11]});
            if (imm) wr(sbc_pkg::ADDR_DDATA, ~seed[31:24]);
            run(iw, 8'h00, 1'b0);
            if (imm) rd(sbc_pkg::ADDR_DDATA, seed[31:24], 8'hFF);
        end
        // Early evaluation: initiator mismatch, then target attention
        xfer_delay <= 8'd40;
        iw.exec_control_code = sbc_pkg::CC_ALW;
        iw.invert = 1'b0;
        iw.irq_req = 1'b1;
        for (int j = 0; j < 2; j++) begin
            bus_stat <= '{atn: j[0], default: '0};
            run(iw, j[0] ? 8'h02 : 8'h06, !j[0]);
        end
        // Odd disconnect in each width mode
        for (int m = 0; m < 4; m++) begin
            wr(sbc_pkg::ADDR_CTRL, 8'h04 | 8'(m << 3));
            byte_moved <= 1'b1;
            tick(1);
            byte_moved <= 1'b0;
            odd_disconnect <= 1'b1;
            tick(1);
            odd_disconnect <= 1'b0;
            {pw, fw} = '0;
            repeat (6) begin
                @(negedge sys_clk);
                pw += pad_word;
                fw += final_word;
            end
            @(posedge sys_clk);
            chk(8'(pw), 8'(m == 2));
            chk(8'(fw), 8'(m == 3));
            rd(sbc_pkg::ADDR_STATUS, {2'b00, m == 1, m % 2 == 0, 4'h0}, 8'h30);
            wr(sbc_pkg::ADDR_STATUS, 8'h20);
        end
        // Residue validity on clean stop and on kill
        clean_stop <= 1'b1;
        tick(1);
        clean_stop <= 1'b0;
        rd(sbc_pkg::ADDR_STATUS, 8'h08, 8'h08);
        residue_kill <= 1'b1;
        tick(1);
        residue_kill <= 1'b0;
        rd(sbc_pkg::ADDR_STATUS, 8'h00, 8'h08);
        // Soft reset, refused writes, then the pin
        wr(sbc_pkg::ADDR_FLAGS, 8'h5A);
        wr(sbc_pkg::ADDR_CTRL, 8'h80);
        rd(sbc_pkg::ADDR_DIAG, 8'h01, 8'hFF);
        wr(sbc_pkg::ADDR_FLAGS, 8'hFF);
        tick(8);
        rd(sbc_pkg::ADDR_FLAGS, 8'h00, 8'hFF);
        rd(sbc_pkg::ADDR_DIAG, 8'h00, 8'h01);
        hw_reset_pin_n <= 1'b0;
        tick(3);
        rd(sbc_pkg::ADDR_DIAG, 8'h01, 8'hFF);
        hw_reset_pin_n <= 1'b1;
        tick(8);
        rd(sbc_pkg::ADDR_DIAG, 8'h00, 8'h01);
        tick(3);
        end_sim();
    end
endmodule : sbc_branch_ctl_tb
